// [hdl/frc_params.svh]
// constants for the frequency reference combiner
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH

// -------------------------------------------------------------
// register offsets (word index on the plain register port)
// -------------------------------------------------------------
`define FRC_REG_MAIN_SEL      4'h0
`define FRC_REG_AUX_SEL       4'h1
`define FRC_REG_AUX_BASIS     4'h2
`define FRC_REG_AUX_PCT       4'h3
`define FRC_REG_COMBINE       4'h4
`define FRC_REG_PRESET        4'h5
`define FRC_REG_DIR           4'h6
`define FRC_REG_MAX_FREQ      4'h7
`define FRC_REG_OFFSET        4'h8
`define FRC_REG_RESOL         4'h9
`define FRC_REG_MAIN_UPDN     4'hA
`define FRC_REG_AUX_UPDN      4'hB
`define FRC_REG_TARGET        4'hC
`define FRC_REG_INIT          4'hD

// -------------------------------------------------------------
// reset values and limits (frequencies in 0.01 Hz units)
// -------------------------------------------------------------
`define FRC_PRESET_RST        32'h0000_1388
`define FRC_MAX_RST           32'h0000_1388
`define FRC_MAX_LO            32'h0000_1388
`define FRC_MAX_HI_FINE       32'h0000_EA60
`define FRC_MAX_HI_COARSE     32'h0004_E200
`define FRC_PCT_MAX           32'h0000_0096
`define FRC_PCT_FULL          32'h0000_0064
`define FRC_SCALE_FULL        32'h0000_1000
`define FRC_RESOL_COARSE      2'h1
`define FRC_RESOL_FINE        2'h2
`define FRC_SWITCH_FUNC       8'h12

`endif

// [hdl/frc_pkg.sv]
// types for the frequency reference combiner
package frc_pkg;
	typedef enum logic [3:0] {
		FRC_SRC_DIG_MEM  = 4'h0,
		FRC_SRC_DIG      = 4'h1,
		FRC_SRC_AIN1     = 4'h2,
		FRC_SRC_AIN2     = 4'h3,
		FRC_SRC_AIN3     = 4'h4,
		FRC_SRC_PULSE    = 4'h5,
		FRC_SRC_MSTAGE   = 4'h6,
		FRC_SRC_PLC      = 4'h7,
		FRC_SRC_PID      = 4'h8,
		FRC_SRC_COMM     = 4'h9
	} frc_src_t;

	typedef enum logic [2:0] {
		FRC_CMB_MAIN     = 3'h0,
		FRC_CMB_OP       = 3'h1,
		FRC_CMB_MAIN_AUX = 3'h2,
		FRC_CMB_MAIN_OP  = 3'h3,
		FRC_CMB_AUX_OP   = 3'h4
	} frc_cmb_t;

	typedef enum logic [1:0] {
		FRC_OP_ADD = 2'h0,
		FRC_OP_SUB = 2'h1,
		FRC_OP_MAX = 2'h2,
		FRC_OP_MIN = 2'h3
	} frc_op_t;
endpackage

// [hdl/frc_combiner.sv]
// frequency reference combiner: main/aux selection, arithmetic, limits
`timescale 1ns/10ps
`default_nettype none
`include "frc_params.svh"

module frc_combiner #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic            CLK,
	input  wire logic            RST_N,
	// register port
	input  wire logic [3:0]      ADDR,
	input  wire logic [31:0]     WDATA,
	input  wire logic            WR,
	input  wire logic            RD,
	output logic      [31:0]     RDATA,
	// source channels, percent in 1/4096 of full scale, signed; COMM_FREQ is a frequency
	input  wire logic [15:0]     ANALOG_INPUT_ONE,
	input  wire logic [15:0]     ANALOG_INPUT_TWO,
	input  wire logic [15:0]     ANALOG_INPUT_THREE,
	input  wire logic [15:0]     PULSE_INPUT_TERMINAL,
	input  wire logic [15:0]     MULTI_STAGE,
	input  wire logic [15:0]     PLC_LEVEL,
	input  wire logic [15:0]     PID_LEVEL,
	input  wire logic [W-1:0]    COMM_FREQ,
	// terminal function 18, frequency switch
	input  wire logic            FREQ_SWITCH,
	// result
	output logic      [W-1:0]    TARGET_FREQ,
	output logic                 DIR_REVERSE
);
	import frc_pkg::*;

	// ---------------------------------------------------------
	// reset synchroniser
	// ---------------------------------------------------------
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ---------------------------------------------------------
	// functions
	// ---------------------------------------------------------
	// percent level (4096 = 100%) times a basis frequency
	function automatic logic signed [W-1:0] scale_pct(
		input logic signed [15:0] lvl, input logic [W-1:0] basis);
		logic signed [W+16:0] p;
		p = $signed({1'b0, basis}) * lvl;
		return p[W+11:12];
	endfunction

	function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
		return v[W-1] ? W'(-v) : v;
	endfunction

	// ---------------------------------------------------------
	// registers
	// ---------------------------------------------------------
	logic [3:0]          main_sel_q, aux_sel_q;
	logic                aux_basis_q, dir_q;
	logic [7:0]          aux_pct_q;
	logic [7:0]          combine_q;
	logic [W-1:0]        preset_q, max_q, offset_q;
	logic [1:0]          resol_q;
	logic signed [W-1:0] main_dig_q, aux_dig_q;

	wire wr_main   = WR && ADDR == `FRC_REG_MAIN_SEL;
	wire wr_aux    = WR && ADDR == `FRC_REG_AUX_SEL;
	wire wr_preset = WR && ADDR == `FRC_REG_PRESET;
	wire wr_resol  = WR && ADDR == `FRC_REG_RESOL;
	wire wr_init   = WR && ADDR == `FRC_REG_INIT;
	wire [1:0] wr_resol_v = (WDATA[1:0] == `FRC_RESOL_COARSE) ?
		`FRC_RESOL_COARSE : `FRC_RESOL_FINE;
	// upper bound of max frequency follows the resolution
	wire [W-1:0] max_hi = (resol_q == `FRC_RESOL_COARSE) ?
		W'(`FRC_MAX_HI_COARSE) : W'(`FRC_MAX_HI_FINE);
	wire [W-1:0] max_wr = (WDATA[W-1:0] < W'(`FRC_MAX_LO)) ? W'(`FRC_MAX_LO) :
		(WDATA[W-1:0] > max_hi) ? max_hi : WDATA[W-1:0];
	// compare the whole word so large writes cannot wrap under the limit
	wire [7:0] pct_wr = (WDATA > `FRC_PCT_MAX) ?
		8'(`FRC_PCT_MAX) : WDATA[7:0];
	wire [W-1:0] preset_wr = (WDATA[W-1:0] > max_q) ? max_q : WDATA[W-1:0];

	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			main_sel_q  <= 4'h0;
			aux_sel_q   <= 4'h0;
			aux_basis_q <= 1'b0;
			aux_pct_q   <= 8'h64;
			combine_q   <= 8'h00;
			preset_q    <= W'(`FRC_PRESET_RST);
			max_q       <= W'(`FRC_MAX_RST);
			offset_q    <= '0;
			resol_q     <= `FRC_RESOL_FINE;
			dir_q       <= 1'b0;
		end else if (wr_init) begin
			// parameter initialisation restores defaults; source selections and resolution keep their values
			aux_basis_q <= 1'b0;
			aux_pct_q   <= 8'h64;
			combine_q   <= 8'h00;
			preset_q    <= W'(`FRC_PRESET_RST);
			max_q       <= W'(`FRC_MAX_RST);
			offset_q    <= '0;
			dir_q       <= 1'b0;
		end else if (WR) begin
			case (ADDR)
			`FRC_REG_MAIN_SEL:  main_sel_q  <= WDATA[3:0];
			`FRC_REG_AUX_SEL:   aux_sel_q   <= WDATA[3:0];
			`FRC_REG_AUX_BASIS: aux_basis_q <= WDATA[0];
			`FRC_REG_AUX_PCT:   aux_pct_q   <= pct_wr;
			`FRC_REG_COMBINE:   combine_q   <= WDATA[7:0];
			`FRC_REG_PRESET:    preset_q    <= preset_wr;
			`FRC_REG_DIR:       dir_q       <= WDATA[0];
			`FRC_REG_MAX_FREQ:  max_q       <= max_wr;
			`FRC_REG_OFFSET:    offset_q    <= (WDATA[W-1:0] > max_q) ?
				max_q : WDATA[W-1:0];
			`FRC_REG_RESOL:     resol_q     <= wr_resol_v;
			default: ;
			endcase
		end
	end

	// ---------------------------------------------------------
	// digital (up/down) setpoints
	// ---------------------------------------------------------
	wire cmb_superpose = combine_q[3:0] == 4'h1 || combine_q[3:0] == 4'h3 ||
		combine_q[3:0] == 4'h4;
	wire aux_dig_src = aux_sel_q == FRC_SRC_DIG_MEM || aux_sel_q == FRC_SRC_DIG;
	// preset loads main digital value; the aux one starts from zero
	// when superposed, so up/down trims ride on the main value
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			main_dig_q <= W'(`FRC_PRESET_RST);
			aux_dig_q  <= W'(`FRC_PRESET_RST);
		end else begin
			if (wr_preset || wr_main || wr_init)
				main_dig_q <= wr_preset ? preset_wr : preset_q;
			else if (WR && ADDR == `FRC_REG_MAIN_UPDN)
				main_dig_q <= main_dig_q + $signed(WDATA[W-1:0]);
			if (wr_preset || wr_aux || wr_init || wr_resol)
				aux_dig_q <= cmb_superpose ? '0 :
					(wr_preset ? preset_wr : preset_q);
			else if (WR && ADDR == `FRC_REG_AUX_UPDN)
				aux_dig_q <= aux_dig_q + $signed(WDATA[W-1:0]);
		end
	end

	// ---------------------------------------------------------
	// channel values
	// ---------------------------------------------------------
	// one channel function serves main and aux alike
	function automatic logic signed [W-1:0] chan(
		input logic [3:0] sel, input logic signed [W-1:0] dig,
		input logic [W-1:0] basis);
		case (sel)
		FRC_SRC_DIG_MEM,
		FRC_SRC_DIG:    return dig;
		FRC_SRC_AIN1:   return scale_pct(ANALOG_INPUT_ONE, basis);
		FRC_SRC_AIN2:   return scale_pct(ANALOG_INPUT_TWO, basis);
		FRC_SRC_AIN3:   return scale_pct(ANALOG_INPUT_THREE, basis);
		FRC_SRC_PULSE:  return scale_pct(PULSE_INPUT_TERMINAL, basis);
		FRC_SRC_MSTAGE: return scale_pct(MULTI_STAGE, basis);
		FRC_SRC_PLC:    return scale_pct(PLC_LEVEL, basis);
		FRC_SRC_PID:    return scale_pct(PID_LEVEL, basis);
		FRC_SRC_COMM:   return COMM_FREQ;
		default:        return '0;
		endcase
	endfunction

	wire signed [W-1:0] main_val = chan(main_sel_q, main_dig_q, max_q);
	// aux range: basis times percent, only in superposition
	wire [W-1:0] basis_v = aux_basis_q ? mag(main_val) : max_q;
	wire [W+7:0] rng_p = basis_v * aux_pct_q;
	wire [W-1:0] aux_rng = W'(rng_p / (W+8)'(`FRC_PCT_FULL));
	wire signed [W-1:0] aux_alone = chan(aux_sel_q, aux_dig_q, max_q);
	wire signed [W-1:0] aux_sup = chan(aux_sel_q, aux_dig_q, aux_rng);

	// ---------------------------------------------------------
	// main/aux operation
	// ---------------------------------------------------------
	wire [1:0] op = combine_q[5:4];
	wire x_big = mag(main_val) >= mag(aux_sup);
	logic signed [W-1:0] op_res;
	always_comb begin
		case (op)
		FRC_OP_ADD: op_res = main_val + aux_sup;
		FRC_OP_SUB: op_res = main_val - aux_sup;
		FRC_OP_MAX: op_res = x_big ? main_val : aux_sup;
		FRC_OP_MIN: op_res = x_big ? aux_sup : main_val;
		default:    op_res = main_val;
		endcase
	end
	wire signed [W-1:0] op_off = op_res + $signed(offset_q);

	// ---------------------------------------------------------
	// selection, direction and clamp
	// ---------------------------------------------------------
	logic signed [W-1:0] sel_v;
	always_comb begin
		case (combine_q[3:0])
		4'h0: sel_v = main_val;
		4'h1: sel_v = op_off;
		4'h2: sel_v = FREQ_SWITCH ? aux_alone : main_val;
		4'h3: sel_v = FREQ_SWITCH ? op_off : main_val;
		4'h4: sel_v = FREQ_SWITCH ? op_off : aux_sup;
		default: sel_v = main_val;
		endcase
	end
	wire [W-1:0] sel_mag = mag(sel_v);
	wire [W-1:0] clamp_mag = (sel_mag > max_q) ? max_q : sel_mag;
	wire neg = sel_v[W-1] ^ dir_q;
	// coarse resolution drops the hundredths digit
	wire [W-1:0] res_mag = (resol_q == `FRC_RESOL_COARSE) ?
		clamp_mag - clamp_mag % W'(10) : clamp_mag;
	wire [W-1:0] tgt_d = neg ? W'(-res_mag) : res_mag;

	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			TARGET_FREQ <= '0;
			DIR_REVERSE <= 1'b0;
		end else begin
			TARGET_FREQ <= tgt_d;
			DIR_REVERSE <= dir_q;
		end
	end

	// ---------------------------------------------------------
	// read back
	// ---------------------------------------------------------
	logic [31:0] rd_v;
	always_comb begin
		case (ADDR)
		`FRC_REG_MAIN_SEL:  rd_v = 32'(main_sel_q);
		`FRC_REG_AUX_SEL:   rd_v = 32'(aux_sel_q);
		`FRC_REG_AUX_BASIS: rd_v = 32'(aux_basis_q);
		`FRC_REG_AUX_PCT:   rd_v = 32'(aux_pct_q);
		`FRC_REG_COMBINE:   rd_v = 32'(combine_q);
		`FRC_REG_PRESET:    rd_v = 32'(preset_q);
		`FRC_REG_DIR:       rd_v = 32'(dir_q);
		`FRC_REG_MAX_FREQ:  rd_v = 32'(max_q);
		`FRC_REG_OFFSET:    rd_v = 32'(offset_q);
		`FRC_REG_RESOL:     rd_v = 32'(resol_q);
		`FRC_REG_MAIN_UPDN: rd_v = 32'(main_dig_q);
		`FRC_REG_AUX_UPDN:  rd_v = 32'(aux_dig_q);
		`FRC_REG_TARGET:    rd_v = 32'(TARGET_FREQ);
		default:            rd_v = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q)
			RDATA <= 32'h0000_0000;
		else
			RDATA <= RD ? rd_v : 32'h0000_0000;
	end
endmodule
`default_nettype wire

// [tb/frc_combiner_asserts.sv]
// port checker for the frequency reference combiner
`timescale 1ns/10ps
`default_nettype none
`include "frc_params.svh"
module frc_combiner_asserts #(
	parameter int W = 32
) (
	// watched ports
	input  wire logic         CLK,
	input  wire logic         RST_N,
	input  wire logic [3:0]   ADDR,
	input  wire logic [31:0]  WDATA,
	input  wire logic         WR,
	input  wire logic         RD,
	input  wire logic [31:0]  RDATA,
	input  wire logic         FREQ_SWITCH,
	input  wire logic [W-1:0] TARGET_FREQ,
	input  wire logic         DIR_REVERSE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [W-1:0] mag;
	assign mag = TARGET_FREQ[W-1] ? W'(-TARGET_FREQ) : TARGET_FREQ;
	a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (RD && ADDR > `FRC_REG_INIT |=> RDATA == 32'h0)
		else $error("unmapped read not zero");
	a_target_read: assert property (RD && ADDR == `FRC_REG_TARGET |=> RDATA == $past(TARGET_FREQ))
		else $error("target readback differs");
	a_dir_follow: assert property (WR && ADDR == `FRC_REG_DIR |-> ##2 DIR_REVERSE == $past(WDATA[0], 2))
		else $error("direction output wrong");
	a_init_dir: assert property (WR && ADDR == `FRC_REG_INIT |-> ##2 !DIR_REVERSE)
		else $error("init kept reversal");
	a_pct_limit: assert property (RD && ADDR == `FRC_REG_AUX_PCT |=> RDATA <= `FRC_PCT_MAX)
		else $error("percent above limit");
	a_max_range: assert property (RD && ADDR == `FRC_REG_MAX_FREQ |=> RDATA >= `FRC_MAX_LO && RDATA <= `FRC_MAX_HI_COARSE)
		else $error("max frequency out of range");
	a_res_legal: assert property (RD && ADDR == `FRC_REG_RESOL |=> RDATA inside {32'h1, 32'h2})
		else $error("resolution illegal");
	a_target_cap: assert property (mag <= W'(`FRC_MAX_HI_COARSE))
		else $error("target beyond ceiling");
	c_combine: cover property (WR && ADDR == `FRC_REG_COMBINE);
	c_switch: cover property ($rose(FREQ_SWITCH));
	c_reverse: cover property (DIR_REVERSE && TARGET_FREQ[W-1]);
endmodule
bind frc_combiner frc_combiner_asserts #(.W(W)) u_chk (.CLK(CLK), .RST_N(RST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.FREQ_SWITCH(FREQ_SWITCH), .TARGET_FREQ(TARGET_FREQ), .DIR_REVERSE(DIR_REVERSE));
`default_nettype wire

// [tb/frc_combiner_tb.sv]
// self-checking bench for the frequency reference combiner
`timescale 1ns/10ps
`default_nettype none
`include "frc_params.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; $display("ERROR t=%0t got %0d exp %0d", $time, a, e); end end
module frc_combiner_tb;
	import frc_pkg::*;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, sw = 0;
	logic [3:0]  addr = 0;
	logic [31:0] wdata = 0, rdata, tgt, comm = 0, v;
	logic [15:0] ain1 = 0, ain2 = 0, ain3 = 0, pin = 0, mst = 0, plc = 0, pid = 0;
	logic        dir;
	int          num_errors = 0, compares = 0, cyc = 0;
	int          lv[5] = '{30000, 15000, 7500, 45000, 22500};
	always #2.5 clk = ~clk;
	frc_combiner dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .ANALOG_INPUT_ONE(ain1),
		.ANALOG_INPUT_TWO(ain2), .ANALOG_INPUT_THREE(ain3),
		.PULSE_INPUT_TERMINAL(pin), .MULTI_STAGE(mst), .PLC_LEVEL(plc),
		.PID_LEVEL(pid), .COMM_FREQ(comm), .FREQ_SWITCH(sw),
		.TARGET_FREQ(tgt), .DIR_REVERSE(dir));
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// three edges cover the setting and output register stages
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic row(input logic [7:0] c, input logic s, input int e);
		wr_reg(`FRC_REG_COMBINE, {24'h0, c});
		@(posedge clk) sw <= s;
		settle();
		`CHK(tgt, e);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_reg(`FRC_REG_PRESET); `CHK(v, 5000);
		rd_reg(`FRC_REG_MAX_FREQ); `CHK(v, 5000);
		rd_reg(`FRC_REG_RESOL); `CHK(v, 2);
		rd_reg(`FRC_REG_DIR); `CHK(v, 0);
		rd_reg(`FRC_REG_TARGET); `CHK(v, 5000);
		rd_reg(4'hE); `CHK(v, 0);
		$display("reset values done");
	endtask
	task automatic t_limits();
		wr_reg(`FRC_REG_MAX_FREQ, 100); rd_reg(`FRC_REG_MAX_FREQ); `CHK(v, 5000);
		wr_reg(`FRC_REG_MAX_FREQ, 400000); rd_reg(`FRC_REG_MAX_FREQ); `CHK(v, 60000);
		wr_reg(`FRC_REG_RESOL, 3); rd_reg(`FRC_REG_RESOL); `CHK(v, 2);
		wr_reg(`FRC_REG_RESOL, 1); wr_reg(`FRC_REG_MAX_FREQ, 400000);
		rd_reg(`FRC_REG_MAX_FREQ); `CHK(v, 320000);
		wr_reg(`FRC_REG_AUX_PCT, 200); rd_reg(`FRC_REG_AUX_PCT); `CHK(v, 150);
		wr_reg(`FRC_REG_RESOL, 2); wr_reg(`FRC_REG_MAX_FREQ, 60000);
		$display("limits done");
	endtask
	task automatic t_sources();
		@(posedge clk) begin
			ain1 <= 16'h0800; ain2 <= 16'h0400; ain3 <= 16'h0200;
			pin <= 16'h0C00; mst <= 16'h0600;
		end
		wr_reg(`FRC_REG_COMBINE, 32'h02);
		// main and aux always on different channels
		for (int i = 0; i < 5; i++) begin
			wr_reg(`FRC_REG_MAIN_SEL, 2 + i);
			wr_reg(`FRC_REG_AUX_SEL, 2 + (i + 1) % 5);
			@(posedge clk) sw <= 1'b0;
			settle(); `CHK(tgt, lv[i]);
			@(posedge clk) sw <= 1'b1;
			settle(); `CHK(tgt, lv[(i + 1) % 5]);
		end
		$display("sources done");
	endtask
	task automatic t_combine();
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_AIN1);
		wr_reg(`FRC_REG_AUX_SEL, FRC_SRC_AIN2);
		wr_reg(`FRC_REG_AUX_PCT, 50);
		wr_reg(`FRC_REG_OFFSET, 1000);
		row(8'h00, 0, 30000);
		row(8'h01, 0, 38500);
		row(8'h11, 0, 23500);
		row(8'h21, 0, 31000);
		row(8'h31, 0, 8500);
		row(8'h03, 0, 30000);
		row(8'h03, 1, 38500);
		row(8'h04, 0, 7500);
		row(8'h04, 1, 38500);
		@(posedge clk) ain2 <= 16'hFC00;
		row(8'h31, 0, -6500);
		row(8'h21, 0, 31000);
		@(posedge clk) ain2 <= 16'h0400;
		wr_reg(`FRC_REG_AUX_BASIS, 1);
		row(8'h01, 0, 34750);
		wr_reg(`FRC_REG_AUX_BASIS, 0);
		wr_reg(`FRC_REG_AUX_PCT, 150);
		row(8'h01, 0, 53500);
		@(posedge clk) ain1 <= 16'h1000;
		row(8'h01, 0, 60000);
		$display("combine done");
	endtask
	task automatic t_digital();
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_DIG_MEM);
		wr_reg(`FRC_REG_AUX_SEL, FRC_SRC_DIG);
		settle(); `CHK(tgt, 6000);
		wr_reg(`FRC_REG_AUX_UPDN, 500);
		settle(); `CHK(tgt, 6500);
		$display("digital aux done");
	endtask
	task automatic t_direction();
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_AIN1);
		wr_reg(`FRC_REG_COMBINE, 0);
		wr_reg(`FRC_REG_DIR, 1);
		settle(); `CHK(dir, 1'b1);
		`CHK(tgt, -60000);
		wr_reg(`FRC_REG_INIT, 0);
		settle(); `CHK(dir, 1'b0);
		rd_reg(`FRC_REG_DIR); `CHK(v, 0);
		$display("direction done");
	endtask
	task automatic t_other_src();
		@(posedge clk) begin
			plc <= 16'h0800; pid <= 16'hF800; comm <= 32'd1234;
		end
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_PLC);
		settle(); `CHK(tgt, 2500);
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_PID);
		settle(); `CHK(tgt, -2500);
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_COMM);
		settle(); `CHK(tgt, 1234);
		wr_reg(`FRC_REG_RESOL, 1);
		settle(); `CHK(tgt, 1230);
		wr_reg(`FRC_REG_MAIN_SEL, FRC_SRC_DIG);
		wr_reg(`FRC_REG_PRESET, 3007);
		settle(); `CHK(tgt, 3000);
		wr_reg(`FRC_REG_PRESET, 9000);
		rd_reg(`FRC_REG_PRESET); `CHK(v, 5000);
		wr_reg(`FRC_REG_AUX_PCT, 300);
		rd_reg(`FRC_REG_AUX_PCT); `CHK(v, 150);
		wr_reg(`FRC_REG_RESOL, 2);
		$display("other sources done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_limits();
		t_sources();
		t_combine();
		t_digital();
		t_direction();
		t_other_src();
		give_verdict();
	end
endmodule
`default_nettype wire
